// [rtl/dsbp_pkg.sv]
// shared types and constants of the delta-sigma bitstream port
package dsbp_pkg;

	// output mode, in the order of the {high, low} select pin code
	typedef enum logic [1:0] {
		DSBP_MODE_SYNC,
		DSBP_MODE_HALF,
		DSBP_MODE_MANCH,
		DSBP_MODE_EXT
	} dsbp_mode_type;

	// two-way clock pin as output value and output enable
	typedef struct packed {
		logic o;
		logic oe;
	} dsbp_pin_type;

	// fabric clock and internal oscillator timing
	localparam int SYS_CLK_PERIOD_NS = 4;
	localparam int INT_OSC_FREQ_MHZ  = 20;
	localparam int INT_OSC_HALF_NS   = 1000 / (2 * INT_OSC_FREQ_MHZ);
	localparam int OSC_HALF_INT      = INT_OSC_HALF_NS / SYS_CLK_PERIOD_NS;
	localparam logic [3:0] OSC_HALF_CYC =
		4'((OSC_HALF_INT < 1) ? 1 : OSC_HALF_INT);

	// modulator arithmetic, input code in units of 0.1 mV
	localparam int SAMPLE_W = 16;
	localparam int ACC_W    = 24;
	localparam logic signed [ACC_W-1:0] DAC_LEVEL   = 24'sh0010AB;
	localparam logic signed [ACC_W-1:0] ACC2_BOUND  = 24'sh010AB0;

	// reset values
	localparam logic       OUT_RST  = 1'h0;
	localparam logic [3:0] CNT_RST  = 4'h0;
	localparam logic signed [ACC_W-1:0] ACC_RST = 24'sh000000;

endpackage

// [rtl/dsbp_modulator.sv]
// second-order one-bit delta-sigma modulator core
`timescale 1ns/1ns
module dsbp_modulator (
	input  wire logic                               clk,
	input  wire logic                               rst_n,
	input  wire logic                               step,
	input  wire logic signed [dsbp_pkg::SAMPLE_W-1:0] din,
	output logic                                    bit_q
);
	import dsbp_pkg::*;

	logic signed [ACC_W-1:0] acc1_q;
	logic signed [ACC_W-1:0] acc2_q;
	logic signed [ACC_W-1:0] acc1_d;
	logic signed [ACC_W-1:0] acc2_d;
	logic signed [ACC_W-1:0] fb;
	logic signed [ACC_W-1:0] din_ext;

	always_comb begin
		din_ext = ACC_W'(din);
		fb      = bit_q ? DAC_LEVEL : -DAC_LEVEL;
		acc1_d  = acc1_q + din_ext - fb;
		acc2_d  = acc2_q + acc1_d - fb;
	end

	// integrators and comparator advance once per modulator bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc1_q <= ACC_RST;
			acc2_q <= ACC_RST;
			bit_q  <= OUT_RST;
		end else if (step) begin
			acc1_q <= acc1_d;
			acc2_q <= acc2_d;
			bit_q  <= ~acc2_d[ACC_W-1];
		end
	end

	loop_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
		(acc2_q < ACC2_BOUND) && (acc2_q > -ACC2_BOUND))
		else $error("second integrator left its stable range");

	bit_sign_a: assert property (@(posedge clk) disable iff (!rst_n)
		step |=> (bit_q == ($past(acc2_d) >= 0)))
		else $error("bit does not follow integrator sign");

endmodule

// [rtl/dsbp_top.sv]
// digital output port of a one-bit delta-sigma modulator
`timescale 1ns/1ns
// Notes on behaviour
// - ones density near 50% at zero, 80% at +256 mV, 20% at -256 mV.
// - select pins high/low pick modes 0 to 3 as {high, low} binary.
// - system clock is internal 20 MHz, or external; mode sets pin direction.
// - modulator clock is the system clock divided by two.
// - mode 0 drives modulator clock out; data changes on its falling edge.
// - mode 1 drives half modulator clock; data changes between its edges.
// - mode 2 sends Manchester data on one line; clock pin held low.
// - mode 3 stops oscillator; outside drives clock pin at twice bit rate.
// - mode 3 data changes on every second external clock falling edge.
// - mode 3 also drives modulator clock on a separate output pin.
module dsbp_top (
	input  wire logic                               SYS_CLK,
	input  wire logic                               RST_N,
	input  wire logic                               MODE_SEL_LOW_BIT,
	input  wire logic                               MODE_SEL_HIGH_BIT,
	input  wire logic                               SYS_CLOCK_PIN_I,
	input  wire logic signed [dsbp_pkg::SAMPLE_W-1:0] ANALOG_CODE,
	output dsbp_pkg::dsbp_pin_type                  SYS_CLOCK_PIN,
	output logic                                    BITSTREAM_OUT,
	output logic                                    MODULATOR_CLOCK_OUT
);
	import dsbp_pkg::*;

	logic          lo_s1_q;
	logic          lo_s2_q;
	logic          hi_s1_q;
	logic          hi_s2_q;
	dsbp_mode_type mode_q;
	logic          ext_s1_q;
	logic          ext_s2_q;
	logic          ext_s3_q;
	logic [3:0]    osc_cnt_q;
	logic          osc_q;
	logic          osc_tick;
	logic          sys_rise;
	logic          sys_fall;
	logic          modclk_q;
	logic          half_q;
	logic          step;
	logic          mod_bit;
	dsbp_mode_type mode_prev_q;
	logic          mode_steady;

	// select pins come from outside, two flops each
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			lo_s1_q <= OUT_RST;
			lo_s2_q <= OUT_RST;
			hi_s1_q <= OUT_RST;
			hi_s2_q <= OUT_RST;
		end else begin
			lo_s1_q <= MODE_SEL_LOW_BIT;
			lo_s2_q <= lo_s1_q;
			hi_s1_q <= MODE_SEL_HIGH_BIT;
			hi_s2_q <= hi_s1_q;
		end
	end

	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_q <= DSBP_MODE_SYNC;
		end else begin
			mode_q <= dsbp_mode_type'({hi_s2_q, lo_s2_q});
		end
	end

	// external system clock pin, synchronised, third flop for edges
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			ext_s1_q <= OUT_RST;
			ext_s2_q <= OUT_RST;
			ext_s3_q <= OUT_RST;
		end else begin
			ext_s1_q <= SYS_CLOCK_PIN_I;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	// oscillator held stopped in external mode
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			osc_cnt_q <= CNT_RST;
			osc_q     <= OUT_RST;
		end else if (mode_q == DSBP_MODE_EXT) begin
			osc_cnt_q <= CNT_RST;
			osc_q     <= OUT_RST;
		end else if (osc_tick) begin
			osc_cnt_q <= CNT_RST;
			osc_q     <= ~osc_q;
		end else begin
			osc_cnt_q <= osc_cnt_q + 4'h1;
		end
	end

	assign osc_tick = (osc_cnt_q == OSC_HALF_CYC - 4'h1);

	// system clock edge events from the selected source
	always_comb begin
		if (mode_q == DSBP_MODE_EXT) begin
			sys_rise = ext_s2_q & ~ext_s3_q;
			sys_fall = ~ext_s2_q & ext_s3_q;
		end else begin
			sys_rise = osc_tick & ~osc_q;
			sys_fall = osc_tick & osc_q;
		end
	end

	// modulator clock toggles on system clock rise
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			modclk_q <= OUT_RST;
		end else if (sys_rise) begin
			modclk_q <= ~modclk_q;
		end
	end

	// half-rate clock toggles on modulator clock rise
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			half_q <= OUT_RST;
		end else if (sys_rise && !modclk_q) begin
			half_q <= ~half_q;
		end
	end

	// internal modes step at the modulator clock fall
	// external mode steps on a system clock fall, every other one
	always_comb begin
		if (mode_q == DSBP_MODE_EXT) begin
			step = sys_fall & ~modclk_q;
		end else begin
			step = sys_rise & modclk_q;
		end
	end

	dsbp_modulator u_mod (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.step  (step),
		.din   (ANALOG_CODE),
		.bit_q (mod_bit)
	);

	// clock pin direction and level per mode
	// clock pin low in Manchester mode
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			SYS_CLOCK_PIN <= '{o: OUT_RST, oe: OUT_RST};
		end else begin
			SYS_CLOCK_PIN.oe <= (mode_q != DSBP_MODE_EXT);
			case (mode_q)
				DSBP_MODE_SYNC: SYS_CLOCK_PIN.o <= modclk_q;
				DSBP_MODE_HALF: SYS_CLOCK_PIN.o <= half_q;
				default:        SYS_CLOCK_PIN.o <= OUT_RST;
			endcase
		end
	end

	// Manchester: inverted bit first half, true bit second half
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			BITSTREAM_OUT <= OUT_RST;
		end else if (mode_q == DSBP_MODE_MANCH) begin
			BITSTREAM_OUT <= mod_bit ^ ~modclk_q;
		end else begin
			BITSTREAM_OUT <= mod_bit;
		end
	end

	// modulator clock on its own pin in external mode
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			MODULATOR_CLOCK_OUT <= OUT_RST;
		end else begin
			MODULATOR_CLOCK_OUT <= (mode_q == DSBP_MODE_EXT) & modclk_q;
		end
	end

	// helper: mode unchanged since the previous cycle
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			mode_prev_q <= DSBP_MODE_SYNC;
		end else begin
			mode_prev_q <= mode_q;
		end
	end

	assign mode_steady = (mode_q == mode_prev_q);

	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	mode_decode_a: assert property (
		##2 (mode_q == dsbp_mode_type'($past({hi_s2_q, lo_s2_q}))))
		else $error("mode does not follow select pins");

	osc_half_a: assert property (
		(mode_q != DSBP_MODE_EXT) && $changed(osc_q) && mode_steady
		|-> $past(osc_cnt_q) == OSC_HALF_CYC - 4'h1)
		else $error("internal oscillator half period wrong");

	modclk_div_a: assert property (
		$changed(modclk_q) |-> $past(sys_rise))
		else $error("modulator clock moved without system clock rise");

	sync_data_edge_a: assert property (
		(mode_q == DSBP_MODE_SYNC) && mode_steady && $past(mode_steady)
		&& $changed(BITSTREAM_OUT) |-> $fell(SYS_CLOCK_PIN.o))
		else $error("mode 0 data changed off the clock fall");

	half_data_mid_a: assert property (
		(mode_q == DSBP_MODE_HALF) && mode_steady && $past(mode_steady)
		&& $changed(BITSTREAM_OUT) |-> $stable(SYS_CLOCK_PIN.o))
		else $error("mode 1 data changed on a clock edge");

	manch_pin_low_a: assert property (
		(mode_q == DSBP_MODE_MANCH) |=>
		!SYS_CLOCK_PIN.o && SYS_CLOCK_PIN.oe)
		else $error("clock pin not held low in mode 2");

	manch_mid_bit_a: assert property (
		(mode_q == DSBP_MODE_MANCH) && mode_steady && $rose(modclk_q)
		##1 (mode_q == DSBP_MODE_MANCH) |-> $changed(BITSTREAM_OUT))
		else $error("Manchester mid-bit transition missing");

	ext_osc_off_a: assert property (
		(mode_q == DSBP_MODE_EXT) |=> !SYS_CLOCK_PIN.oe ##0 !osc_q)
		else $error("oscillator or pin driver active in mode 3");

	ext_data_fall_a: assert property (
		(mode_q == DSBP_MODE_EXT) && $past(mode_q == DSBP_MODE_EXT, 2)
		&& $changed(BITSTREAM_OUT) |-> $past(sys_fall, 2))
		else $error("mode 3 data changed off an external fall");

	ext_modulator_clock_out_a: assert property (
		(mode_q == DSBP_MODE_EXT) && mode_steady
		&& $rose(MODULATOR_CLOCK_OUT) |-> $stable(BITSTREAM_OUT))
		else $error("data moved at clock-out rise in mode 3");

	sync_data_c: cover property (
		(mode_q == DSBP_MODE_SYNC) && $changed(BITSTREAM_OUT));
	half_clock_c: cover property (
		(mode_q == DSBP_MODE_HALF) && $rose(SYS_CLOCK_PIN.o));
	manch_data_c: cover property (
		(mode_q == DSBP_MODE_MANCH) && $changed(BITSTREAM_OUT));
	ext_step_c: cover property ((mode_q == DSBP_MODE_EXT) && step);

endmodule

// [testbench/dsbp_filter_model.sv]
// receiving filter model: samples the bitstream and counts ones
`timescale 1ns/1ns
module dsbp_filter_model (
	input  wire logic       clk,
	input  wire logic [1:0] mode,
	input  wire logic       strobe_clk,
	input  wire logic       data,
	input  wire logic       ext_run,
	output logic            ext_clk,
	output int              bits,
	output int              ones,
	output int              word
);
	// low-OSR sinc3 first stage; the bench expects the full-scale word 4096 of OSR 16
	localparam int OSR = 16;
	logic prev_q = 1'b0;
	int   div_q  = 0;
	int   i1 = 0, i2 = 0, i3 = 0, c1 = 0, c2 = 0, c3 = 0, n = 0;
	int   t1, t2;
	logic take;

	initial begin
		ext_clk = 1'b0;
		bits    = 0;
		ones    = 0;
		word    = 0;
	end

	// external clock, stands low when not in use
	always @(posedge clk) begin
		div_q <= (div_q == 4) ? 0 : div_q + 1;
		if (div_q == 4)
			ext_clk <= ext_run & ~ext_clk;
	end

	// rising edges, or both edges of the half clock
	assign take = (strobe_clk & ~prev_q) |
		((mode == 2'h1) & (strobe_clk ^ prev_q));

	// sinc3: integrate each bit, comb once per OSR bits
	always @(posedge clk) begin
		prev_q <= strobe_clk;
		if (take) begin
			bits <= bits + 1;
			ones <= ones + int'(data);
			i1 = i1 + int'(data);
			i2 = i2 + i1;
			i3 = i3 + i2;
			n = (n == OSR - 1) ? 0 : n + 1;
			if (n == 0) begin
				t1 = i3 - c1;
				c1 = i3;
				t2 = t1 - c2;
				c2 = t1;
				word <= t2 - c3;
				c3 = t2;
			end
		end
	end
endmodule

// [testbench/dsbp_top_tb.sv]
// self-checking bench of the bitstream port
`timescale 1ns/1ns
module dsbp_top_tb;
	import dsbp_pkg::*;
	localparam int WIN = 6000;
	localparam int BIT = 4 * int'(OSC_HALF_CYC);
	logic                      sys_clk = 1'b0;
	logic                      rst_n   = 1'b0;
	logic                      sel_lo  = 1'b0;
	logic                      sel_hi  = 1'b0;
	logic                      ext_run = 1'b0;
	logic signed [SAMPLE_W-1:0] code   = '0;
	logic [31:0]               lfsr    = 32'h16E3F09A;
	logic [2:0]                watch   = 3'h4;
	logic                      prev_d  = 1'b0;
	logic                      prev_o  = 1'b0;
	dsbp_pin_type              pin;
	logic                      dout, mclk_out, ext_clk, strobe;
	int failures = 0, compares = 0, bits, ones, rises = 0, edges = 0;
	int word;
	wire pin_lvl = pin.oe ? pin.o : ext_clk;

	always #2 sys_clk = ~sys_clk;

	dsbp_top uut (.SYS_CLK(sys_clk), .RST_N(rst_n),
		.MODE_SEL_LOW_BIT(sel_lo), .MODE_SEL_HIGH_BIT(sel_hi),
		.SYS_CLOCK_PIN_I(pin_lvl), .ANALOG_CODE(code),
		.SYS_CLOCK_PIN(pin), .BITSTREAM_OUT(dout),
		.MODULATOR_CLOCK_OUT(mclk_out));

	// mode 3 data is taken on the modulator clock output
	assign strobe = ({sel_hi, sel_lo} == 2'h3) ? mclk_out : pin.o;

	dsbp_filter_model far (.clk(sys_clk), .mode({sel_hi, sel_lo}),
		.strobe_clk(strobe), .data(dout), .ext_run(ext_run),
		.ext_clk(ext_clk), .bits(bits), .ones(ones), .word(word));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
			input string what);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t %s got %0h want %0h", $time, what, seen, exp);
		end
	endtask

	task automatic close_out;
		$display("compares %0d failures %0d", compares, failures);
		if (failures == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// expected ones percentage, 30 points per 256 mV
	function automatic int want_pct(input int c);
		return 50 + c * 30 / 2560;
	endfunction

	function automatic logic near(input int got, input int exp, input int tol);
		return (got >= exp - tol) && (got <= exp + tol);
	endfunction

	// data may move only where modes 0, 1 and 3 allow
	always @(posedge sys_clk) begin
		prev_d <= dout;
		prev_o <= pin.o;
		if (pin.o & ~prev_o)
			rises <= rises + 1;
		if (dout != prev_d) begin
			edges <= edges + 1;
			if (watch == 3'h0)
				check(prev_o & ~pin.o, 1, "mode0 edge");
			if (watch == 3'h1)
				check(pin.o ^ prev_o, 0, "mode1 edge");
			if (watch == 3'h3)
				check(mclk_out, 0, "mode3 edge");
		end
	end

	task automatic set_mode(input logic [1:0] m);
		@(posedge sys_clk);
		watch <= 3'h4;
		{sel_hi, sel_lo} <= m;
		ext_run <= (m == 2'h3);
		repeat (200) @(posedge sys_clk);
	endtask

	task automatic density(input logic signed [SAMPLE_W-1:0] c,
			input int per_bit, input int per_pin);
		int b0, o0, r0, pct;
		@(posedge sys_clk);
		code <= c;
		repeat (100) @(posedge sys_clk);
		watch <= {1'b0, sel_hi, sel_lo};
		b0 = bits;
		o0 = ones;
		r0 = rises;
		repeat (WIN) @(posedge sys_clk);
		pct = (bits > b0) ? (ones - o0) * 100 / (bits - b0) : 0;
		check(near(bits - b0, WIN / per_bit, 1), 1, "bit rate");
		check(near(rises - r0, per_pin ? WIN / per_pin : 0, 1), 1,
			"pin rate");
		check(near(pct, want_pct(int'(c)), 3), 1, "density");
		check(near(word, want_pct(int'(c)) * 4096 / 100, 410), 1,
			"filter word");
		$display("done mode %0d code %0d pct %0d", {sel_hi, sel_lo}, c, pct);
	endtask

	initial begin
		int e0;
		repeat (10) @(posedge sys_clk);
		check({pin, dout, mclk_out}, 0, "reset outputs");
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		// select codes 0, 1 and 3, corner and random levels
		for (int m = 0; m < 4; m++) begin
			if (m == 2)
				continue;
			set_mode(m[1:0]);
			check(pin.oe, m != 3, "pin direction");
			density(16'sh0000, m == 3 ? 20 : BIT,
				m == 0 ? BIT : m == 1 ? 2 * BIT : 0);
			density(16'sh0A00, m == 3 ? 20 : BIT,
				m == 0 ? BIT : m == 1 ? 2 * BIT : 0);
			density(-16'sh0A00, m == 3 ? 20 : BIT,
				m == 0 ? BIT : m == 1 ? 2 * BIT : 0);
			lfsr = next_rand(lfsr);
			density(SAMPLE_W'($signed(lfsr[11:0])), m == 3 ? 20 : BIT,
				m == 0 ? BIT : m == 1 ? 2 * BIT : 0);
		end
		// single-line coding, clock pin held low
		set_mode(2'h2);
		e0 = edges;
		repeat (WIN) @(posedge sys_clk);
		check({pin.o, pin.oe}, 2'h1, "mode2 pin");
		check(near(edges - e0, 3 * WIN / (2 * BIT), WIN / (2 * BIT) + 1), 1,
			"transitions");
		$display("done manchester edges %0d", edges - e0);
		close_out();
	end

	// watchdog at 95000 cycles, some 15000 beyond the expected run length of about 80000
	initial begin
		#(4 * 95000);
		failures++;
		close_out();
	end
endmodule
